// >>> hw/eis_pkg.sv
// Constants shared by the external interrupt synchronizer files.
package eis_pkg;

    // ========================================================================
    // Source counts and index layout
    // ========================================================================
    localparam int NUM_REQ   = 4;   // Dedicated request pins.
    localparam int NUM_STD   = 8;   // Standard general-purpose pins.
    localparam int NUM_WAKE  = 8;   // Wake-up general-purpose pins.
    localparam int NUM_SRC   = NUM_REQ + NUM_STD + NUM_WAKE;
    localparam int BASE_STD  = NUM_REQ;            // First standard index.
    localparam int BASE_WAKE = NUM_REQ + NUM_STD;  // First wake-up index.
    localparam int ID_W      = 5;   // Width of a source index.

    // ========================================================================
    // Latency figures in peripheral-clock cycles
    // ========================================================================
    localparam int REQ_LATENCY   = 10;  // Request pin to core input.
    localparam int GP_LATENCY    = 12;  // General-purpose pin to core input.
    // Cycles spent in two sync stages, flag and output flop; edge detect is combinational.
    localparam int PIPE_OVERHEAD = 4;
    localparam int REQ_DELAY     = REQ_LATENCY - PIPE_OVERHEAD;
    localparam int GP_DELAY      = GP_LATENCY - PIPE_OVERHEAD;

endpackage

// >>> hw/eis_src_if.sv
// Interface carrying one group's enable, clear and pending vectors.
`timescale 1ns/1ps

interface eis_src_if #(parameter int N = 4);
    logic [N-1:0] enable;   // Event capture allowed, per source.
    logic [N-1:0] clear;    // Pending clear pulse, per source.
    logic [N-1:0] pending;  // Pending flag, per source.

    // Capture side holds the flags.
    modport leaf (input enable, input clear, output pending);
    // Mapping side steers and reads them.
    modport core (output enable, output clear, input pending);
endinterface

// >>> hw/eis_src_sync.sv
// One group of interrupt inputs: synchroniser, delay line, pending flags.
`timescale 1ns/1ps

module eis_src_sync #(
    parameter int N     = 4,
    parameter int DELAY = 6
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Asynchronous pins, active high.
    input  wire logic [N-1:0] pin,
    // Flag group.
    eis_src_if.leaf           grp
);

    // ========================================================================
    // Parameter check
    // ========================================================================
    if (DELAY < 1 || N < 1)
    begin : g_bad_param
        $error("eis_src_sync needs DELAY and N of at least one.");
    end

    logic [N-1:0] meta;            // First stage, read only by stage two.
    logic [N-1:0] stable;          // Second stage, safe to use.
    logic [N-1:0] stable_d;        // Stage two delayed, for edge detect.
    logic [N-1:0] rise;            // Rising edge seen on the stable copy.
    logic [N-1:0] dly [DELAY];     // Delay line that sets the latency.

    // ========================================================================
    // Synchroniser
    // ========================================================================
    // Two flops bring each pin into the clock domain before any use.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            meta     <= '0;
            stable   <= '0;
            stable_d <= '0;
        end
        else
        begin
            meta     <= pin;
            stable   <= meta;
            stable_d <= stable;
        end
    end

    // An event is a low to high change after synchronisation.
    assign rise = stable & ~stable_d;

    // ========================================================================
    // Delay line
    // ========================================================================
    // Pads the path so the core input rises at the fixed latency.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int k = 0; k < DELAY; k++)
            begin
                dly[k] <= '0;
            end
        end
        else
        begin
            dly[0] <= rise;
            for (int k = 1; k < DELAY; k++)
            begin
                dly[k] <= dly[k-1];
            end
        end
    end

    // ========================================================================
    // Pending flags
    // ========================================================================
    // A flag already set absorbs a new event, so repeats are neither counted
    // nor queued. An arriving event wins over a clear in the same cycle.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            grp.pending <= '0;
        end
        else
        begin
            grp.pending <= (grp.pending & ~grp.clear)
                         | (dly[DELAY-1] & grp.enable);
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    // A flag never drops unless a clear was given.
    property p_pend_sticky;
        @(posedge clk) disable iff (reset)
        1'b1 |=> ((~grp.pending & $past(grp.pending)
                   & ~$past(grp.clear)) == '0);
    endproperty
    a_pend_sticky: assert property (p_pend_sticky)
        else $error("Pending flag dropped without a clear.");

    // A new flag has a synchronised edge exactly DELAY+1 cycles before.
    property p_pend_cause;
        @(posedge clk) disable iff (reset)
        ((grp.pending & ~$past(grp.pending)
          & ~$past(rise, DELAY + 1)) == '0);
    endproperty
    a_pend_cause: assert property (p_pend_cause)
        else $error("Pending flag set without a matching edge.");

    // A new flag needs capture enabled one cycle before.
    property p_pend_enable;
        @(posedge clk) disable iff (reset)
        ((grp.pending & ~$past(grp.pending) & ~$past(grp.enable)) == '0);
    endproperty
    a_pend_enable: assert property (p_pend_enable)
        else $error("Pending flag set while capture was disabled.");

    // The stable copy follows the first stage after one edge.
    sequence s_meta_high;
        meta[0] ##1 meta[0];
    endsequence
    property p_two_stage;
        @(posedge clk) disable iff (reset)
        s_meta_high |-> stable[0];
    endproperty
    a_two_stage: assert property (p_two_stage)
        else $error("Second sync stage did not follow the first.");

endmodule

// >>> hw/eis_top.sv
// External interrupt synchronizer: capture, flag and map to core inputs.
//
// Contract
// - Accept four request, eight standard, eight wake pins.
// - Standard pins raise nothing during power-down.
// - Synchronise every input before mapping.
// - Request pins reach core in ten cycles.
// - General-purpose pins reach normal core in twelve.
// - Latencies hold only for uncontested enabled sources.
// - Repeat while pending is ignored, not queued.
`timescale 1ns/1ps

module eis_top (
    // Clock and reset.
    input  wire logic                        CLK_SYS,
    input  wire logic                        RESET,
    // Interrupt pins, asynchronous, active high.
    input  wire logic [eis_pkg::NUM_REQ-1:0]  REQ_PIN,
    input  wire logic [eis_pkg::NUM_STD-1:0]  STD_GP_PIN,
    input  wire logic [eis_pkg::NUM_WAKE-1:0] WAKE_PIN,
    // Controls from on-chip logic on the same clock.
    input  wire logic                        POWER_DOWN,
    input  wire logic                        REQ0_CRITICAL,
    input  wire logic [eis_pkg::NUM_SRC-1:0]  SRC_ENABLE,
    input  wire logic [eis_pkg::NUM_SRC-1:0]  SRC_MASK,
    input  wire logic [eis_pkg::NUM_SRC-1:0]  PEND_CLEAR,
    // Core interrupt inputs and status.
    output logic                             CORE_CRIT_INT,
    output logic                             CORE_NORM_INT,
    output logic      [eis_pkg::NUM_SRC-1:0]  PENDING,
    output logic      [eis_pkg::ID_W-1:0]     NORM_SRC_ID,
    output logic                             NORM_SRC_VALID
);

    // ========================================================================
    // Groups
    // ========================================================================
    eis_src_if #(.N(eis_pkg::NUM_REQ))  req_if  ();
    eis_src_if #(.N(eis_pkg::NUM_STD))  std_if  ();
    eis_src_if #(.N(eis_pkg::NUM_WAKE)) wake_if ();

    logic [eis_pkg::NUM_SRC-1:0] unmasked;   // Pending and not masked.
    logic [eis_pkg::NUM_SRC-1:0] norm_act;   // Sources routed to normal.
    logic                        crit_act;   // Request zero routed critical.
    logic [eis_pkg::ID_W-1:0]    next_id;    // Winning normal source.

    // Capture enables: standard pins are shut off in power-down.
    assign req_if.enable  = SRC_ENABLE[eis_pkg::BASE_STD-1:0];
    assign std_if.enable  = SRC_ENABLE[eis_pkg::BASE_WAKE-1:eis_pkg::BASE_STD]
                          & {eis_pkg::NUM_STD{~POWER_DOWN}};
    assign wake_if.enable = SRC_ENABLE[eis_pkg::NUM_SRC-1:eis_pkg::BASE_WAKE];

    // Clear pulses split per group.
    assign req_if.clear  = PEND_CLEAR[eis_pkg::BASE_STD-1:0];
    assign std_if.clear  = PEND_CLEAR[eis_pkg::BASE_WAKE-1:eis_pkg::BASE_STD];
    assign wake_if.clear = PEND_CLEAR[eis_pkg::NUM_SRC-1:eis_pkg::BASE_WAKE];

    // Flags gathered in index order: requests, standard, wake-up.
    assign PENDING = {wake_if.pending, std_if.pending, req_if.pending};

    // ========================================================================
    // Capture groups
    // ========================================================================
    // Request pins get the shorter delay line.
    eis_src_sync #(
        .N     (eis_pkg::NUM_REQ),
        .DELAY (eis_pkg::REQ_DELAY)
    ) u_req (
        .clk   (CLK_SYS),
        .reset (RESET),
        .pin   (REQ_PIN),
        .grp   (req_if)
    );

    // Standard general-purpose pins.
    eis_src_sync #(
        .N     (eis_pkg::NUM_STD),
        .DELAY (eis_pkg::GP_DELAY)
    ) u_std (
        .clk   (CLK_SYS),
        .reset (RESET),
        .pin   (STD_GP_PIN),
        .grp   (std_if)
    );

    // Wake-up pins stay live in power-down.
    eis_src_sync #(
        .N     (eis_pkg::NUM_WAKE),
        .DELAY (eis_pkg::GP_DELAY)
    ) u_wake (
        .clk   (CLK_SYS),
        .reset (RESET),
        .pin   (WAKE_PIN),
        .grp   (wake_if)
    );

    // ========================================================================
    // Mapping and priority
    // ========================================================================
    // Request zero goes to the critical input when selected, else normal.
    always_comb
    begin
        unmasked    = PENDING & ~SRC_MASK;
        norm_act    = unmasked;
        norm_act[0] = unmasked[0] & ~REQ0_CRITICAL;
        crit_act    = unmasked[0] & REQ0_CRITICAL;
    end

    // Lowest index wins; others wait, which lengthens their latency.
    always_comb
    begin
        next_id = '0;
        for (int i = eis_pkg::NUM_SRC - 1; i >= 0; i--)
        begin
            if (norm_act[i])
            begin
                next_id = eis_pkg::ID_W'(i);
            end
        end
    end

    // ========================================================================
    // Core outputs
    // ========================================================================
    // One output flop closes the fixed latency of each path.
    always_ff @(posedge CLK_SYS)
    begin
        if (RESET)
        begin
            CORE_CRIT_INT  <= 1'b0;
            CORE_NORM_INT  <= 1'b0;
            NORM_SRC_ID    <= '0;
            NORM_SRC_VALID <= 1'b0;
        end
        else
        begin
            CORE_CRIT_INT  <= crit_act;
            CORE_NORM_INT  <= |norm_act;
            NORM_SRC_ID    <= next_id;
            NORM_SRC_VALID <= |norm_act;
        end
    end

    // ========================================================================
    // Checks
    // ========================================================================
    // Request zero in critical mode raises the critical input next edge.
    sequence s_req0_crit;
        req_if.pending[0] && !SRC_MASK[0] && REQ0_CRITICAL;
    endsequence
    property p_req0_crit;
        @(posedge CLK_SYS) disable iff (RESET)
        s_req0_crit |=> CORE_CRIT_INT;
    endproperty
    a_req0_crit: assert property (p_req0_crit)
        else $error("Critical request did not reach the critical input.");

    // A new request flag on pins one to three reaches normal next edge.
    property p_req_norm;
        @(posedge CLK_SYS) disable iff (RESET)
        ((req_if.pending[3:1] & ~SRC_MASK[3:1]) != '0) |=> CORE_NORM_INT;
    endproperty
    a_req_norm: assert property (p_req_norm)
        else $error("Request flag did not reach the normal input.");

    // Unmasked general-purpose flags reach the normal input next edge.
    property p_gp_norm;
        @(posedge CLK_SYS) disable iff (RESET)
        ((PENDING[eis_pkg::NUM_SRC-1:eis_pkg::BASE_STD]
          & ~SRC_MASK[eis_pkg::NUM_SRC-1:eis_pkg::BASE_STD]) != '0)
        |=> CORE_NORM_INT && NORM_SRC_VALID;
    endproperty
    a_gp_norm: assert property (p_gp_norm)
        else $error("General-purpose flag did not reach the normal input.");

    // No standard flag rises in the cycle after power-down was active.
    property p_pd_quiet;
        @(posedge CLK_SYS) disable iff (RESET)
        POWER_DOWN |=> ((std_if.pending & ~$past(std_if.pending)) == '0);
    endproperty
    a_pd_quiet: assert property (p_pd_quiet)
        else $error("Standard pin flagged an event in power-down.");

    // The reported source was active and no lower index was.
    property p_prio;
        @(posedge CLK_SYS) disable iff (RESET)
        (norm_act != '0) |=> NORM_SRC_ID == $past(next_id)
                          && $past(norm_act[next_id])
                          && $past((norm_act
                                    & ~({eis_pkg::NUM_SRC{1'b1}} << next_id))
                                   == '0);
    endproperty
    a_prio: assert property (p_prio)
        else $error("Reported source was not the winning active one.");

    // With all flags clear both core inputs are low next edge.
    property p_idle;
        @(posedge CLK_SYS) disable iff (RESET)
        (PENDING == '0) |=> !CORE_NORM_INT && !CORE_CRIT_INT;
    endproperty
    a_idle: assert property (p_idle)
        else $error("Core interrupt raised with no pending flag.");

    // With only request zero flagged in critical mode, normal stays low.
    sequence s_req0_alone;
        REQ0_CRITICAL
        && (PENDING == {{(eis_pkg::NUM_SRC-1){1'b0}}, 1'b1});
    endsequence
    property p_req0_alone;
        @(posedge CLK_SYS) disable iff (RESET)
        s_req0_alone |=> !CORE_NORM_INT;
    endproperty
    a_req0_alone: assert property (p_req0_alone)
        else $error("Critical request zero also raised the normal input.");

    // The critical input rises only for a routed, unmasked request zero.
    property p_crit_cause;
        @(posedge CLK_SYS) disable iff (RESET)
        CORE_CRIT_INT |-> $past(req_if.pending[0] && !SRC_MASK[0]
                                && REQ0_CRITICAL);
    endproperty
    a_crit_cause: assert property (p_crit_cause)
        else $error("Critical input raised without request zero routed.");

    // The normal input rises only while some unmasked flag is set.
    property p_norm_cause;
        @(posedge CLK_SYS) disable iff (RESET)
        CORE_NORM_INT |-> $past((PENDING & ~SRC_MASK) != '0);
    endproperty
    a_norm_cause: assert property (p_norm_cause)
        else $error("Normal input raised with no unmasked flag.");

endmodule

// >>> tb/eis_src_model.sv
// Behavioural model of the external interrupt sources driving the pins.
`timescale 1ns/1ps

module eis_src_model (
    // Clock seen by the sources, used only to time pulses.
    input  wire logic                        clk,
    // All twenty pins: request, standard, then wake-up.
    output logic      [eis_pkg::NUM_SRC-1:0] pins
);
    // ========================================================================
    // Pulse generation
    // ========================================================================
    logic [eis_pkg::NUM_SRC-1:0] start;     // Pulse requests from the bench.
    int                          cnt [eis_pkg::NUM_SRC];  // Cycles left high.

    initial
    begin
        pins  = '0;
        start = '0;
        foreach (cnt[k]) cnt[k] = 0;
    end

    // Asks for one pulse on a source; it starts at the next falling edge.
    task automatic pulse(input int idx);
        start[idx] = 1'b1;
    endtask

    // Each pulse is held high for two whole cycles, so the synchroniser
    // always sees it; the pin then returns low and stays low.
    always @(negedge clk)
    begin
        for (int i = 0; i < eis_pkg::NUM_SRC; i++)
        begin
            if (start[i])
            begin
                pins[i]  <= 1'b1;
                cnt[i]   <= 2;
                start[i] = 1'b0;
            end
            else if (cnt[i] > 0)
            begin
                cnt[i] <= cnt[i] - 1;
                if (cnt[i] == 1) pins[i] <= 1'b0;
            end
        end
    end
endmodule

// >>> tb/testbench.sv
// Self-checking testbench of the external interrupt synchronizer.
`timescale 1ns/1ps

// One comparison: counts it and reports a mismatch at once.
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    miscompares++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); \
    end end

module testbench;
    // ========================================================================
    // Signals
    // ========================================================================
    logic                        clk_sys = 1'b0;  // Peripheral clock.
    logic                        reset   = 1'b1;  // Synchronous reset.
    logic                        power_down = 1'b0;
    logic                        req0_crit  = 1'b0;
    logic [eis_pkg::NUM_SRC-1:0] enable = '1;     // All sources enabled.
    logic [eis_pkg::NUM_SRC-1:0] mask   = '0;     // Nothing masked.
    logic [eis_pkg::NUM_SRC-1:0] clear  = '0;     // Clear pulses.
    logic [eis_pkg::NUM_SRC-1:0] pins;            // Pins from the sources.
    logic [eis_pkg::NUM_SRC-1:0] pending;         // Flags from the design.
    logic [eis_pkg::ID_W-1:0]    src_id;          // Winning source index.
    logic                        crit_int;        // Critical core input.
    logic                        norm_int;        // Normal core input.
    logic                        src_valid;       // Index valid.
    int                          miscompares = 0; // Mismatches seen.
    int                          n_tests = 0;     // Comparisons made.

    // Half period of 12.5 ns gives the 40 MHz clock.
    always #12.5 clk_sys = ~clk_sys;

    // ========================================================================
    // Design and source model
    // ========================================================================
    eis_src_model i_eis_src_model (.clk(clk_sys), .pins(pins));

    eis_top i_eis_top (
        .CLK_SYS        (clk_sys),
        .RESET          (reset),
        .REQ_PIN        (pins[3:0]),
        .STD_GP_PIN     (pins[11:4]),
        .WAKE_PIN       (pins[19:12]),
        .POWER_DOWN     (power_down),
        .REQ0_CRITICAL  (req0_crit),
        .SRC_ENABLE     (enable),
        .SRC_MASK       (mask),
        .PEND_CLEAR     (clear),
        .CORE_CRIT_INT  (crit_int),
        .CORE_NORM_INT  (norm_int),
        .PENDING        (pending),
        .NORM_SRC_ID    (src_id),
        .NORM_SRC_VALID (src_valid)
    );

    // ========================================================================
    // Helpers
    // ========================================================================
    // Waits n rising edges and lets their updates settle.
    task automatic edges(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Pulses the clear inputs for one cycle, launched at a falling edge.
    task automatic clr(input logic [eis_pkg::NUM_SRC-1:0] v);
        @(negedge clk_sys);
        clear = v;
        @(negedge clk_sys);
        clear = '0;
    endtask

    // Fires source i and checks the exact flag and output timing; flags
    // already set must belong to higher indices than i.
    task automatic fire(input int i);
        logic [eis_pkg::NUM_SRC-1:0] ev;
        logic [eis_pkg::NUM_SRC-1:0] base;  // Flags set before the pulse.
        int                          lat;
        ev  = '0;
        ev[i] = 1'b1;
        lat = (i < eis_pkg::NUM_REQ) ? eis_pkg::REQ_LATENCY
                                     : eis_pkg::GP_LATENCY;
        @(posedge clk_sys);
        #1;
        base = pending;
        i_eis_src_model.pulse(i);
        edges(lat - 1);
        `CHK("flag", base | ev, pending)
        `CHK("early out", |base, norm_int | crit_int)
        edges(1);
        if (i == 0 && req0_crit)
        begin
            `CHK("crit", 1'b1, crit_int)
            `CHK("norm off", 1'b0, norm_int)
        end
        else
        begin
            `CHK("norm", 1'b1, norm_int)
            `CHK("id", eis_pkg::ID_W'(i), src_id)
            `CHK("valid", 1'b1, src_valid)
        end
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    // Every source on its own, then request zero on the critical input.
    task automatic t_latency();
        for (int i = 0; i < eis_pkg::NUM_SRC; i++)
        begin
            fire(i);
            clr('1);
            edges(1);
            `CHK("cleared", 3'b000, {norm_int, src_valid, |pending})
        end
        @(negedge clk_sys);
        req0_crit = 1'b1;
        fire(0);
        clr('1);
        edges(1);
        `CHK("crit drop", 1'b0, crit_int)
        @(negedge clk_sys);
        req0_crit = 1'b0;
    endtask

    // A repeat while pending is lost; the mask gates only the output.
    task automatic t_repeat_mask();
        fire(5);
        edges(2);
        i_eis_src_model.pulse(5);
        edges(14);
        `CHK("one flag", 20'h00020, pending)
        @(negedge clk_sys);
        mask[5] = 1'b1;
        edges(2);
        `CHK("masked out", 1'b0, norm_int)
        `CHK("kept flag", 20'h00020, pending)
        @(negedge clk_sys);
        mask[5] = 1'b0;
        clr('1);
        edges(14);
        `CHK("no queue", 2'b00, {norm_int, |pending})
    endtask

    // A disabled source and a standard pin in power-down set no flag.
    task automatic t_enable_power();
        @(negedge clk_sys);
        enable[7] = 1'b0;
        i_eis_src_model.pulse(7);
        edges(16);
        `CHK("disabled", 20'h00000, pending)
        @(negedge clk_sys);
        enable[7]  = 1'b1;
        power_down = 1'b1;
        i_eis_src_model.pulse(4);
        edges(16);
        `CHK("power down std", 20'h00000, pending)
        fire(12);
        clr('1);
        @(negedge clk_sys);
        power_down = 1'b0;
    endtask

    // Two pending sources: the lower index is reported first.
    task automatic t_priority();
        fire(15);
        fire(2);
        `CHK("winner", 5'h02, src_id)
        clr(20'h00004);
        edges(2);
        `CHK("next", 5'h0F, src_id)
        `CHK("still on", 1'b1, norm_int)
        clr('1);
        edges(2);
    endtask

    // ========================================================================
    // Verdict, watchdog and main sequence
    // ========================================================================
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // The tests need under a thousand cycles; four thousand means a hang.
    initial
    begin
        repeat (4000) @(posedge clk_sys);
        miscompares++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        edges(1);
        `CHK("reset out", 3'b000, {crit_int, norm_int, |pending})
        t_latency();
        t_repeat_mask();
        t_enable_power();
        t_priority();
        close_out();
    end
endmodule
